// ---- hw/i2c_port_pkg.sv ----
package i2c_port_pkg;

    // ------------------------------------------------------------
    // mode encodings and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_MASTER = 4'h8;
    localparam logic [3:0] MODE_SLAVE7 = 4'h6;
    localparam logic [3:0] MODE_SLAVE10 = 4'h7;
    localparam logic [6:0] BAUD_RESET = 7'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
    localparam logic [3:0] BIT_COUNT_LAST = 4'h8;
    localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    // baud counter steps on two phases of a four-phase instruction cycle
    localparam int PHASES_PER_CYCLE = 4;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    // fixed-width bit positions in the write-control group
    localparam int CTRL_LOW_BITS = 5;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] port_mode_select;
        logic port_enable;
        logic general_call_enable;
        logic start_request;
        logic stop_request;
    } control_type;

    typedef struct packed {
        logic buffer_full_flag;
        logic write_collision_flag;
        logic bus_collision_flag;
        logic serial_port_irq_flag;
        logic update_address_flag;
        logic ack_received_status;
        logic start_seen;
        logic stop_seen;
        logic general_call_hit;
        logic start_request;
        logic stop_request;
    } status_type;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_START_WAIT = 9'h002,
        ST_START_HOLD = 9'h004,
        ST_TX_LOW = 9'h008,
        ST_TX_HIGH = 9'h010,
        ST_STOP_LOW = 9'h020,
        ST_STOP_HIGH = 9'h040,
        ST_STOP_DONE = 9'h080,
        ST_HOLD = 9'h100
    } master_state_type;

endpackage

// ---- hw/i2c_port.sv ----
`timescale 1ns/10ps
// Function
// - all-zero address with write bit is a fixed general call match
// - general call matches only while general call enable is set
// - on general call: byte to buffer, buffer full, irq at ninth fall
// - 10-bit slave general call leaves update-address clear, no 2nd byte
// - start-seen and stop-seen clear on reset and when port disabled
// - master irq on start done, stop done and byte done after the ack bit
// - no queueing: buffer write during pending start is dropped, write_collision_flag set
// - master sends 7-bit address then read/write bit, 0 write, 1 read
// - bytes are eight bits, each followed by one acknowledge bit
// - baud reload from low seven address bits; starts on buffer write
// - baud counter steps on Q2 and Q4 down to zero, then stops
// - master reload is automatic, waits for scl sampled high
// - start: lines high load counter; high at timeout pull sda low
// - then one more period; clear start request, keep sda low
// - scl low before sda driven low: bus collision, back to idle
// - buffer write during start keeps buffer, sets write collision
// - start and stop request bit writes ignored while start is in progress
// - after eight bits sample ack into status, irq after ninth clock
// - stop request makes stop condition, irq once it completes
// - transfer ends with stop only, no repeated start, bus kept until the stop
// - own address compares shift bits 7:1 at eighth scl fall
// - ack status cleared on sda low, set on sda high
module i2c_port (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_link,
    input wire i2c_port_pkg::control_type ctrl,
    input wire logic ctrl_write,
    input wire logic [7:0] address_baud_reg,
    input wire logic [7:0] buffer_wdata,
    input wire logic buffer_write,
    input wire logic buffer_read,
    input wire logic irq_clear,
    input wire logic write_collision_flag_clear,
    input wire logic bcol_clear,
    input wire logic sda_in,
    input wire logic scl_in,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    output logic [7:0] serial_buffer,
    output i2c_port_pkg::status_type status
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        i2c_port_pkg::master_state_type mst;
        logic [1:0] phase;
        logic [6:0] baud_counter;
        logic [7:0] serial_shift_reg;
        logic [7:0] serial_buffer;
        logic [3:0] bit_count;
        logic sda_low;
        logic scl_low;
        logic start_request;
        logic stop_request;
        logic general_call_enable;
        logic buffer_full_flag;
        logic write_collision_flag;
        logic bus_collision_flag;
        logic serial_port_irq_flag;
        logic update_address_flag;
        logic ack_received_status;
        logic start_seen;
        logic stop_seen;
        logic general_call_hit;
        logic [1:0] sda_sync;
        logic [1:0] scl_sync;
        logic [1:0] scl_hist;
        logic [1:0] sda_hist;
        logic [1:0] slv_rise_sync;
        logic slv_rise_seen;
        logic [3:0] slv_count;
    } state_type;

    // link-side sampler: flips a toggle on every link clock rise, no scl
    // input and no byte; the system side only synchronises the toggle
    typedef struct packed {
        logic toggle;
    } link_type;

    state_type q, d;
    link_type lq, ld;

    wire logic master_mode;
    wire logic slave_mode;
    wire logic baud_step;
    wire logic baud_zero;
    wire logic sda_s;
    wire logic scl_s;
    wire logic scl_rise;
    wire logic scl_fall;
    wire logic start_cond;
    wire logic stop_cond;
    wire logic start_busy;
    wire logic gc_match;
    wire logic own_match;

    assign master_mode = ctrl.port_enable &&
        ctrl.port_mode_select == i2c_port_pkg::MODE_MASTER;
    assign slave_mode = ctrl.port_enable && !master_mode;
    assign sda_s = q.sda_sync[1];
    assign scl_s = q.scl_sync[1];
    // edge checks read the second stage history only
    assign scl_rise = q.scl_hist == 2'b01;
    assign scl_fall = q.scl_hist == 2'b10;
    assign start_cond = q.scl_hist[0] && q.sda_hist == 2'b10;
    assign stop_cond = q.scl_hist[0] && q.sda_hist == 2'b01;
    assign baud_step = q.phase == i2c_port_pkg::PHASE_Q2 ||
        q.phase == i2c_port_pkg::PHASE_Q4;
    assign baud_zero = q.baud_counter == i2c_port_pkg::BAUD_RESET;
    assign start_busy = q.mst == i2c_port_pkg::ST_START_WAIT ||
        q.mst == i2c_port_pkg::ST_START_HOLD;
    assign gc_match = q.general_call_enable &&
        q.serial_shift_reg == i2c_port_pkg::GENERAL_CALL_ADDR;
    assign own_match = q.serial_shift_reg[7:1] ==
        address_baud_reg[7:1];

    // ------------------------------------------------------------
    // link clock domain: free-running toggle, not used by the slave path
    // ------------------------------------------------------------
    always_comb begin
        ld = lq;
        ld.toggle = ~lq.toggle;
    end

    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    // ------------------------------------------------------------
    // system domain
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.phase = q.phase + 2'h1;
        d.sda_sync = {q.sda_sync[0], sda_in};
        d.scl_sync = {q.scl_sync[0], scl_in};
        d.scl_hist = {q.scl_hist[0], scl_s};
        d.sda_hist = {q.sda_hist[0], sda_s};
        d.slv_rise_sync = {q.slv_rise_sync[0], lq.toggle};
        d.slv_rise_seen = q.slv_rise_sync[1];
        d.general_call_enable = ctrl.general_call_enable;

        // software clears; hardware sets below win over these
        if (irq_clear) begin
            d.serial_port_irq_flag = 1'b0;
        end
        if (write_collision_flag_clear) begin
            d.write_collision_flag = 1'b0;
        end
        if (bcol_clear) begin
            d.bus_collision_flag = 1'b0;
        end
        if (buffer_read) begin
            d.buffer_full_flag = 1'b0;
        end

        // control writes: start and stop request bits locked during a start
        if (ctrl_write && !start_busy) begin
            d.start_request = ctrl.start_request;
            d.stop_request = ctrl.stop_request;
        end

        // baud counter counts down on q2 and q4, stops at zero
        if (!baud_zero && baud_step) begin
            d.baud_counter = q.baud_counter - 7'h01;
        end

        // bus condition monitor
        if (start_cond) begin
            d.start_seen = 1'b1;
            d.stop_seen = 1'b0;
            d.slv_count = i2c_port_pkg::BIT_COUNT_RESET;
            d.general_call_hit = 1'b0;
        end
        if (stop_cond) begin
            d.stop_seen = 1'b1;
            d.start_seen = 1'b0;
        end

        // ---------------- slave receive path ----------------
        if (slave_mode) begin
            // ack clock must not advance the count or the ninth fall is lost
            if (scl_rise && q.slv_count < i2c_port_pkg::BIT_COUNT_LAST) begin
                d.serial_shift_reg = {q.serial_shift_reg[6:0], sda_s};
                d.slv_count = q.slv_count + 4'h1;
            end
            if (scl_fall && q.slv_count == i2c_port_pkg::BIT_COUNT_LAST) begin
                // address compared at the eighth fall
                if (gc_match || own_match) begin
                    d.serial_buffer = q.serial_shift_reg;
                    d.buffer_full_flag = 1'b1;
                    d.general_call_hit = gc_match;
                    // general call in 10-bit mode needs no second byte
                    if (ctrl.port_mode_select == i2c_port_pkg::MODE_SLAVE10
                        && !gc_match) begin
                        d.update_address_flag = 1'b1;
                    end
                    d.sda_low = 1'b1;
                end
                d.slv_count = q.slv_count + 4'h1;
            end
            if (scl_fall && q.slv_count == i2c_port_pkg::BIT_COUNT_LAST +
                4'h1) begin
                if (q.sda_low) begin
                    d.serial_port_irq_flag = 1'b1;
                end
                d.sda_low = 1'b0;
                d.slv_count = i2c_port_pkg::BIT_COUNT_RESET;
            end
        end

        // ---------------- master sequencer ----------------
        case (q.mst)
        i2c_port_pkg::ST_IDLE: begin
            if (master_mode && q.start_request) begin
                if (!sda_s && !scl_s) begin
                    d.bus_collision_flag = 1'b1;
                    d.start_request = 1'b0;
                end else if (sda_s && scl_s) begin
                    d.baud_counter = address_baud_reg[6:0];
                    d.mst = i2c_port_pkg::ST_START_WAIT;
                end
            end else if (master_mode && q.stop_request) begin
                d.sda_low = 1'b1;
                d.scl_low = 1'b1;
                d.baud_counter = address_baud_reg[6:0];
                d.mst = i2c_port_pkg::ST_STOP_LOW;
            end
        end
        i2c_port_pkg::ST_START_WAIT: begin
            if (!scl_s) begin
                d.bus_collision_flag = 1'b1;
                d.start_request = 1'b0;
                d.mst = i2c_port_pkg::ST_IDLE;
            end else if (baud_zero && sda_s) begin
                d.sda_low = 1'b1;
                d.start_seen = 1'b1;
                d.baud_counter = address_baud_reg[6:0];
                d.mst = i2c_port_pkg::ST_START_HOLD;
            end
        end
        i2c_port_pkg::ST_START_HOLD: begin
            if (baud_zero) begin
                d.start_request = 1'b0;
                d.serial_port_irq_flag = 1'b1;
                d.mst = i2c_port_pkg::ST_HOLD;
            end
        end
        i2c_port_pkg::ST_HOLD: begin
            // bus kept low between operations; only a stop, a buffer write or a port disable leaves
            if (q.stop_request) begin
                d.scl_low = 1'b1;
                d.sda_low = 1'b1;
                d.baud_counter = address_baud_reg[6:0];
                d.mst = i2c_port_pkg::ST_STOP_LOW;
            end else if (buffer_write) begin
                d.serial_shift_reg = buffer_wdata;
                d.serial_buffer = buffer_wdata;
                d.buffer_full_flag = 1'b1;
                d.bit_count = i2c_port_pkg::BIT_COUNT_RESET;
                d.scl_low = 1'b1;
                d.sda_low = ~buffer_wdata[7];
                d.baud_counter = address_baud_reg[6:0];
                d.mst = i2c_port_pkg::ST_TX_LOW;
            end
        end
        i2c_port_pkg::ST_TX_LOW: begin
            if (baud_zero) begin
                d.scl_low = 1'b0;
                d.mst = i2c_port_pkg::ST_TX_HIGH;
            end
        end
        i2c_port_pkg::ST_TX_HIGH: begin
            // counter held until scl really reads high
            if (!scl_s) begin
                d.baud_counter = address_baud_reg[6:0];
            end else if (baud_zero) begin
                d.scl_low = 1'b1;
                d.baud_counter = address_baud_reg[6:0];
                d.bit_count = q.bit_count + 4'h1;
                d.mst = i2c_port_pkg::ST_TX_LOW;
                if (q.bit_count == i2c_port_pkg::BIT_COUNT_LAST) begin
                    d.ack_received_status = sda_s;
                    d.serial_port_irq_flag = 1'b1;
                    d.mst = i2c_port_pkg::ST_HOLD;
                end else if (q.bit_count == i2c_port_pkg::BIT_COUNT_LAST
                    - 4'h1) begin
                    d.sda_low = 1'b0;
                    d.buffer_full_flag = 1'b0;
                end else begin
                    d.serial_shift_reg = {q.serial_shift_reg[6:0], 1'b0};
                    d.sda_low = ~q.serial_shift_reg[6];
                end
            end
        end
        i2c_port_pkg::ST_STOP_LOW: begin
            if (baud_zero) begin
                d.scl_low = 1'b0;
                d.baud_counter = address_baud_reg[6:0];
                d.mst = i2c_port_pkg::ST_STOP_HIGH;
            end
        end
        i2c_port_pkg::ST_STOP_HIGH: begin
            if (!scl_s) begin
                d.baud_counter = address_baud_reg[6:0];
            end else if (baud_zero) begin
                d.sda_low = 1'b0;
                d.baud_counter = address_baud_reg[6:0];
                d.mst = i2c_port_pkg::ST_STOP_DONE;
            end
        end
        i2c_port_pkg::ST_STOP_DONE: begin
            if (baud_zero) begin
                d.stop_request = 1'b0;
                d.serial_port_irq_flag = 1'b1;
                d.mst = i2c_port_pkg::ST_IDLE;
            end
        end
        default: begin
            d.mst = i2c_port_pkg::ST_IDLE;
        end
        endcase

        // buffer write rejected while a start is pending
        if (buffer_write && master_mode &&
            q.mst != i2c_port_pkg::ST_HOLD) begin
            d.write_collision_flag = 1'b1;
        end

        // disable drops sequencer, lines, requests and seen bits back to idle
        if (!ctrl.port_enable) begin
            d.start_seen = 1'b0;
            d.stop_seen = 1'b0;
            d.mst = i2c_port_pkg::ST_IDLE;
            d.sda_low = 1'b0;
            d.scl_low = 1'b0;
            d.start_request = 1'b0;
            d.stop_request = 1'b0;
            d.slv_count = i2c_port_pkg::BIT_COUNT_RESET;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.mst <= i2c_port_pkg::ST_IDLE;
            q.sda_sync <= 2'b11;
            q.scl_sync <= 2'b11;
            q.scl_hist <= 2'b11;
            q.sda_hist <= 2'b11;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs: open drain, low or released only
    // ------------------------------------------------------------
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe = q.sda_low;
    assign scl_oe = q.scl_low;
    assign serial_buffer = q.serial_buffer;
    assign status.buffer_full_flag = q.buffer_full_flag;
    assign status.write_collision_flag = q.write_collision_flag;
    assign status.bus_collision_flag = q.bus_collision_flag;
    assign status.serial_port_irq_flag = q.serial_port_irq_flag;
    assign status.update_address_flag = q.update_address_flag;
    assign status.ack_received_status = q.ack_received_status;
    assign status.start_seen = q.start_seen;
    assign status.stop_seen = q.stop_seen;
    assign status.general_call_hit = q.general_call_hit;
    assign status.start_request = q.start_request;
    assign status.stop_request = q.stop_request;

endmodule // i2c_port

// ---- tb/i2c_port_props.sv ----
`timescale 1ns/10ps
module i2c_port_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_link,
    input wire i2c_port_pkg::control_type ctrl,
    input wire logic ctrl_write,
    input wire logic [7:0] address_baud_reg,
    input wire logic [7:0] buffer_wdata,
    input wire logic buffer_write,
    input wire logic buffer_read,
    input wire logic irq_clear,
    input wire logic write_collision_flag_clear,
    input wire logic bcol_clear,
    input wire logic sda_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic [7:0] serial_buffer,
    input wire i2c_port_pkg::status_type status
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_PULL_ONLY: assert property (!sda_out && !scl_out)
        else $error("pin driven high");
    AST_WRITE_COLLISION_FLAG_SET: assert property (
        buffer_write && status.start_request |=> status.write_collision_flag)
        else $error("write during start not flagged");
    AST_BUF_KEPT: assert property (
        buffer_write && status.start_request |=> $stable(serial_buffer))
        else $error("buffer changed during start");
    AST_SEEN_CLEAR: assert property (
        !ctrl.port_enable [*3] |-> !(status.start_seen || status.stop_seen))
        else $error("seen bits kept while disabled");
    AST_SCL_FREE: assert property (status.start_request |-> !scl_oe)
        else $error("scl pulled during start");
    // a start may not pull sda within eight cycles of the start request write
    AST_FIRST_WAIT: assert property (
        ctrl_write && ctrl.start_request && !status.start_request && !sda_oe
        |=> !sda_oe [*8])
        else $error("sda pulled too early");
    AST_START_IRQ: assert property (
        $fell(status.start_request) && status.start_seen
        |-> ##[0:2] status.serial_port_irq_flag)
        else $error("no irq after start");
    AST_START_HOLD: assert property (
        $fell(status.start_request) && status.start_seen
        |-> sda_oe && !scl_oe)
        else $error("start end lines wrong");
    AST_BCOL_ABORT: assert property (
        $rose(status.bus_collision_flag)
        |-> ##[0:3] !(status.start_request || sda_oe))
        else $error("start not aborted");
    AST_GC_ENABLED: assert property (
        $rose(status.general_call_hit) |-> ctrl.general_call_enable)
        else $error("general call while disabled");
endmodule // i2c_port_props

bind i2c_port i2c_port_props u_props (
    .clk_sys, .rst, .clk_link, .ctrl, .ctrl_write, .address_baud_reg,
    .buffer_wdata, .buffer_write, .buffer_read, .irq_clear, .write_collision_flag_clear,
    .bcol_clear, .sda_in, .scl_in, .sda_out, .sda_oe, .scl_out, .scl_oe,
    .serial_buffer, .status
);

// ---- tb/i2c_slave_model.sv ----
`timescale 1ns/10ps
module i2c_slave_model (
    input wire logic sda,
    input wire logic scl,
    input wire logic nack,
    input wire logic hold_scl,
    output logic sda_pull,
    output logic scl_pull,
    output logic [7:0] rx_byte
);
    int cnt = 0;
    logic [7:0] sh = 8'h00;
    initial sda_pull = 1'b0;
    initial rx_byte = 8'h00;
    // holding scl low mimics a second master fighting for the bus
    assign scl_pull = hold_scl;
    always @(negedge sda) if (scl === 1'b1) cnt = 0;
    always @(posedge scl) begin
        if (cnt < 8) begin
            sh = {sh[6:0], sda};
            cnt = cnt + 1;
            if (cnt == 8) rx_byte = sh;
        end else if (cnt == 8) cnt = 9;
    end
    always @(negedge scl) begin
        if (cnt == 8) sda_pull = !nack;
        else if (cnt == 9) begin
            sda_pull = 1'b0;
            cnt = 0;
        end
    end
endmodule // i2c_slave_model

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic rst = 1'b1;
    i2c_port_pkg::control_type ctrl = '0;
    logic ctrl_write = 1'b0;
    logic [7:0] address_baud_reg = 8'h00;
    logic [7:0] buffer_wdata = 8'h00;
    logic buffer_write = 1'b0;
    logic buffer_read = 1'b0;
    logic irq_clear = 1'b0;
    logic write_collision_flag_clear = 1'b0;
    logic bcol_clear = 1'b0;
    logic sda_in, scl_in, sda_out, sda_oe, scl_out, scl_oe;
    logic [7:0] serial_buffer, rx_byte;
    i2c_port_pkg::status_type status;
    logic m_sda = 1'b0;
    logic m_scl = 1'b0;
    logic nack = 1'b0;
    logic hold_scl = 1'b0;
    logic s_sda, s_scl;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    int lat, reload, exp_buf;

    always #5 clk_sys = ~clk_sys;
    initial #7 forever #24 clk_link = ~clk_link;
    // open-drain wires with pull-ups
    assign sda_in = !(sda_oe | s_sda | m_sda);
    assign scl_in = !(scl_oe | s_scl | m_scl);

    i2c_port u_dut (
        .clk_sys, .rst, .clk_link, .ctrl, .ctrl_write, .address_baud_reg,
        .buffer_wdata, .buffer_write, .buffer_read, .irq_clear, .write_collision_flag_clear,
        .bcol_clear, .sda_in, .scl_in, .sda_out, .sda_oe, .scl_out, .scl_oe,
        .serial_buffer, .status
    );
    i2c_slave_model u_slave (
        .sda(sda_in), .scl(scl_in), .nack, .hold_scl,
        .sda_pull(s_sda), .scl_pull(s_scl), .rx_byte
    );

    task automatic tally_and_finish();
        if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp, string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                              string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic ctrl_cmd(input logic st, input logic sp);
        ctrl.start_request = st;
        ctrl.stop_request = sp;
        ctrl_write = 1'b1;
        cyc(1);
        ctrl_write = 1'b0;
        ctrl.start_request = 1'b0;
        ctrl.stop_request = 1'b0;
    endtask
    // m: buffer_read, irq_clear, write_collision_flag_clear, bcol_clear
    task automatic clears(input logic [3:0] m);
        {buffer_read, irq_clear, write_collision_flag_clear, bcol_clear} = m;
        cyc(1);
        {buffer_read, irq_clear, write_collision_flag_clear, bcol_clear} = 4'h0;
    endtask
    task automatic wait_irq();
        int i = 0;
        while (status.serial_port_irq_flag !== 1'b1 && i < 3000) begin
            cyc(1);
            i++;
        end
        check_bit(status.serial_port_irq_flag, 1'b1, "irq");
        clears(4'h4);
        cyc(1);
    endtask
    // slow bench master: 20 cycles a phase outlasts the input sync
    task automatic mbit(input logic b);
        m_sda = !b;
        cyc(20);
        m_scl = 1'b0;
        cyc(20);
        m_scl = 1'b1;
        cyc(20);
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'h9fa4c7f1));
        reload = 8 + $urandom_range(7);
        address_baud_reg = reload[7:0];
        cyc(12);
        rst = 1'b0;
        cyc(1);
        check_bit(|status, 1'b0, "status reset");
        check_bit(sda_oe | scl_oe, 1'b0, "oe reset");
        check_byte(serial_buffer, 8'h00, "buf reset");
        exp_buf = 0;
        ctrl.port_mode_select = i2c_port_pkg::MODE_MASTER;
        ctrl.port_enable = 1'b1;
        cyc(2);
        check_bit(status.start_seen | status.stop_seen, 1'b0, "idle");
        ctrl_cmd(1'b1, 1'b0);
        cyc(3);
        buffer_wdata = 8'h5a ^ 8'($urandom);
        buffer_write = 1'b1;
        ctrl_cmd(1'b0, 1'b1);
        buffer_write = 1'b0;
        cyc(1);
        check_bit(status.write_collision_flag, 1'b1, "write_collision_flag");
        check_byte(serial_buffer, exp_buf[7:0], "buf kept");
        check_bit(status.stop_request, 1'b0, "ctrl ignored");
        clears(4'h2);
        lat = 6;
        while (sda_oe !== 1'b1 && lat < 200) begin
            cyc(1);
            lat++;
        end
        check_bit(lat >= 2 * reload && lat <= 2 * reload + 12, 1'b1,
                  "start delay");
        wait_irq();
        check_bit(status.start_seen, 1'b1, "start seen");
        check_bit(status.start_request, 1'b0, "start req");
        check_bit(sda_oe & !scl_oe, 1'b1, "start lines");
        for (int k = 0; k < 2; k++) begin
            nack = k[0] ^ $urandom_range(1);
            buffer_wdata = 8'($urandom);
            if (k == 0) buffer_wdata[0] = 1'b0;
            exp_buf = buffer_wdata;
            buffer_write = 1'b1;
            cyc(1);
            buffer_write = 1'b0;
            wait_irq();
            check_byte(rx_byte, exp_buf[7:0], "wire byte");
            check_bit(status.ack_received_status, nack, "ack");
            check_byte(serial_buffer, exp_buf[7:0], "tx buf");
        end
        ctrl_cmd(1'b0, 1'b1);
        wait_irq();
        check_bit(status.stop_seen, 1'b1, "stop seen");
        check_bit(sda_oe | scl_oe, 1'b0, "released");
        ctrl.port_enable = 1'b0;
        cyc(4);
        check_bit(status.start_seen | status.stop_seen, 1'b0, "seen");
        ctrl.port_enable = 1'b1;
        cyc(4);
        ctrl_cmd(1'b1, 1'b0);
        cyc(4);
        hold_scl = 1'b1;
        cyc(60);
        check_bit(status.bus_collision_flag, 1'b1, "bcol");
        check_bit(status.start_request | sda_oe, 1'b0, "abort");
        hold_scl = 1'b0;
        clears(4'h5);
        for (int c = 0; c < 3; c++) begin
            ctrl.port_enable = 1'b0;
            cyc(2);
            ctrl.port_mode_select = (c == 1) ? i2c_port_pkg::MODE_SLAVE10
                                             : i2c_port_pkg::MODE_SLAVE7;
            ctrl.general_call_enable = (c != 0);
            ctrl.port_enable = 1'b1;
            cyc(4);
            if (c != 0) exp_buf = 0;
            m_sda = 1'b1;
            cyc(20);
            m_scl = 1'b1;
            cyc(20);
            repeat (8) mbit(1'b0);
            mbit(1'b1);
            check_bit(status.general_call_hit, c != 0, "gc hit");
            check_bit(status.serial_port_irq_flag, c != 0, "gc irq");
            check_bit(status.buffer_full_flag, c != 0, "gc full");
            check_bit(status.update_address_flag, 1'b0, "ua");
            check_byte(serial_buffer, exp_buf[7:0], "gc buf");
            m_sda = 1'b1;
            cyc(20);
            m_scl = 1'b0;
            cyc(20);
            m_sda = 1'b0;
            cyc(20);
            clears(4'hc);
        end
        cyc(10);
        tally_and_finish();
    end
endmodule // tb
